// [core/mpt_pkg.sv]
// mpt_pkg: register map, field positions, reset values and carrier types
// shared by the pwm time base, its prescaler and the compare channels.
// assumes a 32-bit apb slave and one core clock at 125 MHz.
package mpt_pkg;

  // apb byte offsets, one aligned word each
  localparam logic [7:0] OFS_CTRL = 8'h00;   // timebase_control_reg
  localparam logic [7:0] OFS_CNT = 8'h04;    // timebase_counter and count_down_flag
  localparam logic [7:0] OFS_PER = 8'h08;    // period_value_reg buffer
  localparam logic [7:0] OFS_OCTL2 = 8'h0c;  // output_control_two_reg
  localparam logic [7:0] OFS_DUTY0 = 8'h10;  // duty_value_one, next three follow
  localparam logic [7:0] OFS_STAT = 8'h20;   // sticky event flag, write one to clear

  // control register fields
  localparam int CTL_EN_BIT = 15;    // timebase_enable_bit
  localparam int CTL_OPS_LSB = 4;    // match_postscale_select, 4 bits
  localparam int CTL_CKPS_LSB = 2;   // input_prescale_select, 2 bits
  localparam int CTL_MODE_LSB = 0;   // timebase_mode_field, 2 bits
  localparam int CNT_DIR_BIT = 15;   // count_down_flag, read only
  localparam int OCTL2_UPDATE_INHIBIT_BIT_BIT = 0; // update_inhibit_bit
  localparam int STAT_FLAG_BIT = 0;  // sticky event flag

  // reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [14:0] CNT_RST = 15'h0000;
  localparam logic [14:0] PER_RST = 15'h0000;
  localparam logic [15:0] DUTY_RST = 16'h0000;

  // timing: core clocks per instruction cycle (oscillator / 4)
  localparam int INSTR_DIV = 4;
  localparam int PRE_CNT_W = 8;      // holds 4 * 64 - 1
  localparam int NUM_DUTY = 4;       // duty generators

  // counting modes, in field order 00..11
  typedef enum logic [1:0] {MPT_FREE, MPT_SINGLE, MPT_UPDN, MPT_DUAL} mpt_mode_e;

  // software control fields
  typedef struct packed {
    logic en;
    logic [3:0] ops;
    logic [1:0] ckps;
    mpt_mode_e mode;
  } mpt_ctrl_s;

  // time base view handed to every compare channel
  typedef struct packed {
    logic [14:0] cnt;
    logic half;
    logic [14:0] per;
    logic center;
  } mpt_view_s;

endpackage

// [core/mpt_prescaler.sv]
// mpt_prescaler: instruction-clock divider plus 1/4/16/64 prescaler
// assumes the caller pulses clr on counter or control writes.
module mpt_prescaler
  import mpt_pkg::*;
#(
  parameter int CNT_W = PRE_CNT_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clkEn,
  // control
  input wire logic clr,
  input wire logic [1:0] sel,
  // results
  output logic tick,
  output logic half,
  output logic [CNT_W-1:0] cnt_q
);

  // the largest ratio must fit the counter
  if (CNT_W < PRE_CNT_W) begin : g_bad_w
    $error("prescaler counter too narrow");
  end

  logic [CNT_W-1:0] limit; // last count of one tick interval

  // core clocks per tick minus one
  always_comb begin
    limit = CNT_W'((INSTR_DIV << (2 * sel)) - 1);
  end

  // tick on the last count; half marks the second half-step
  assign tick = clkEn && (cnt_q == limit);
  assign half = (cnt_q > (limit >> 1));

  // prescaler count, cleared by writes and reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (clkEn) begin
      if (clr || cnt_q >= limit) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

endmodule // mpt_prescaler

// [core/mpt_compare.sv]
// mpt_compare: one duty channel, active duty copy and compare output
// assumes load comes from the time base: a strobe at update instants, held high while disabled (and, in edge modes, not inhibited).
module mpt_compare
  import mpt_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clkEn,
  // time base and buffer
  input wire mpt_view_s view,
  input wire logic load,
  input wire logic [15:0] dutyBuf,
  // results
  output logic [15:0] dutyAct_q,
  output logic out_q
);

  logic [15:0] fine; // count in half-steps
  logic outD;

  // active copy only moves on load, so a period never glitches
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dutyAct_q <= DUTY_RST;
    end else if (clkEn && load) begin
      dutyAct_q <= dutyBuf;
    end
  end

  // compare on the half-step scale
  always_comb begin
    if (view.center) begin
      // level compare equals set going down, clear going up
      fine = {view.cnt, 1'b0};
      outD = (dutyAct_q != '0) && ((fine < dutyAct_q) || (dutyAct_q[15:1] >= view.per));
    end else begin
      // lsb adds the prescaler half-step within each count
      fine = {view.cnt, view.half};
      outD = (fine < dutyAct_q);
    end
  end

  // registered output
  always_ff @(posedge core_clk) begin
    if (reset) begin
      out_q <= 1'b0;
    end else if (clkEn) begin
      out_q <= outD;
    end
  end

  // zero duty never drives the output
  zero_duty_a: assert property (@(posedge core_clk) disable iff (reset)
    clkEn && dutyAct_q == '0 |=> !out_q) else $error("output active with zero duty");

endmodule // mpt_compare

// [core/mpt_timebase_duty.sv]
// mpt_timebase_duty: pwm time base, period and duty double buffers, apb registers
// assumes an apb master on core_clk, synchronous active-high reset,
// and gate drivers that take the compare outputs directly.
//
// Design decisions made here: register access over APB and the register offsets.

// Functional notes
// - up/down: count up to period, then down
// - direction flag reads one while counting down
// - mode 10: event at zero turn, postscaled
// - mode 11: events at zero and match
// - tick is osc/4 divided 1/4/16/64
// - prescaler clears on counter/control write, reset
// - 4-bit postscaler, clears on same writes
// - period buffer loads at reset or zero
// - period copied continuously while disabled
// - edge: active at zero, off at duty
// - edge: zero duty off, large duty on
// - center: on matching down, off matching up
// - center: zero off, duty equal period on
// - four 16-bit duties, lsb half-step
// - duty buffer plus active compare copy
// - edge duty load at match, disabled-not-inhibited
// - mode 10 duty load at zero, disabled
// - mode 11 duty load zero, match, disabled
// - up/down period twice edge period (code gives 2 * period ticks, against period + 1 in edge modes)
// - 00 free running, 01 single shot
// - period zero stops counter and events
// - disabling halts without clearing counter
module mpt_timebase_duty
  import mpt_pkg::*;
#(
  parameter int NUM_CH = NUM_DUTY
) (
  // clock, reset and freeze
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clkEn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // compare outputs and event
  output logic [NUM_CH-1:0] compareOut,
  output logic tbEvent
);

  // refuse channel counts the map cannot hold
  if (NUM_CH < 1 || NUM_CH > NUM_DUTY) begin : g_bad_ch
    $error("NUM_CH must be 1 to 4");
  end

  // ---------------- register state ----------------
  mpt_ctrl_s ctrl_q;               // control fields
  logic [14:0] cnt_q;              // timebase_counter
  logic [14:0] cnt_d;
  logic dir_q;                     // count_down_flag
  logic dir_d;
  logic [14:0] perBuf_q;           // software period buffer
  logic [14:0] perAct_q;           // active period
  logic update_inhibit_bit_q;                    // update_inhibit_bit
  logic [15:0] dutyBuf_q [NUM_CH]; // software duty buffers
  logic [3:0] post_q;              // postscaler count
  logic flag_q;                    // sticky event flag
  logic [31:0] prdata_q;           // registered read data
  logic tbEvent_q;                 // postscaled event pulse

  // ---------------- apb decode ----------------
  logic apbWr;       // write takes effect this edge
  logic apbSetup;    // setup phase, read data captured
  logic wrCtrl;
  logic wrCnt;
  logic wrPer;
  logic wrOctl2;
  logic wrStat;
  logic [7:0] dutyOff;
  logic dutyHit;
  logic [1:0] dutyIdx;
  logic mapped;
  logic [31:0] rdMux;

  // pready follows the freeze so no write is lost while frozen
  assign pready = clkEn;
  assign apbWr = psel && penable && pwrite && clkEn;
  assign apbSetup = psel && !penable && clkEn;

  // duty window sits between the octl2 and status registers
  assign dutyOff = paddr - OFS_DUTY0;
  assign dutyHit = (paddr >= OFS_DUTY0) && (dutyOff < 8'(4 * NUM_CH)) && (dutyOff[1:0] == 2'b00);
  assign dutyIdx = dutyOff[3:2];

  // fixed register strobes
  assign wrCtrl = apbWr && (paddr == OFS_CTRL);
  assign wrCnt = apbWr && (paddr == OFS_CNT);
  assign wrPer = apbWr && (paddr == OFS_PER);
  assign wrOctl2 = apbWr && (paddr == OFS_OCTL2);
  assign wrStat = apbWr && (paddr == OFS_STAT);

  // anything else answers with an error and reads zero
  assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_CNT) || (paddr == OFS_PER)
                  || (paddr == OFS_OCTL2) || (paddr == OFS_STAT) || dutyHit;
  assign pslverr = psel && penable && !mapped;

  // read mux, narrow registers sit in the low bits
  always_comb begin
    rdMux = '0;
    if (paddr == OFS_CTRL) begin
      rdMux[CTL_EN_BIT] = ctrl_q.en;
      rdMux[CTL_OPS_LSB +: 4] = ctrl_q.ops;
      rdMux[CTL_CKPS_LSB +: 2] = ctrl_q.ckps;
      rdMux[CTL_MODE_LSB +: 2] = ctrl_q.mode;
    end else if (paddr == OFS_CNT) begin
      rdMux[14:0] = cnt_q;
      rdMux[CNT_DIR_BIT] = dir_q;
    end else if (paddr == OFS_PER) begin
      rdMux[14:0] = perBuf_q;
    end else if (paddr == OFS_OCTL2) begin
      rdMux[OCTL2_UPDATE_INHIBIT_BIT_BIT] = update_inhibit_bit_q;
    end else if (paddr == OFS_STAT) begin
      rdMux[STAT_FLAG_BIT] = flag_q;
    end else if (dutyHit) begin
      rdMux[15:0] = dutyBuf_q[dutyIdx];
    end
  end

  // read data is caught in setup so it stands through access
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prdata_q <= '0;
    end else if (apbSetup) begin
      prdata_q <= rdMux;
    end
  end
  assign prdata = prdata_q;

  // ---------------- prescaler ----------------
  logic tick;   // one core cycle per prescaled clock
  logic half;   // second half of the tick interval
  logic [PRE_CNT_W-1:0] preCnt;

  mpt_prescaler #(.CNT_W(PRE_CNT_W)) u_pre (
    .core_clk(core_clk),
    .reset(reset),
    .clkEn(clkEn),
    .clr(wrCtrl || wrCnt),
    .sel(ctrl_q.ckps),
    .tick(tick),
    .half(half),
    .cnt_q(preCnt)
  );

  // ---------------- counter step ----------------
  logic center;    // up/down modes
  logic run;       // counter may step this cycle
  logic zeroEvt;   // turn at zero in up/down
  logic matchEvt;  // period match
  logic rawEvt;    // mode-selected event
  logic usesPost;  // postscaler applies
  logic fire;      // event after postscaler
  logic perLoad;   // active period takes buffer
  logic dutyLoad;  // active duties take buffers

  assign center = (ctrl_q.mode == MPT_UPDN) || (ctrl_q.mode == MPT_DUAL);
  // a zero period freezes the counter and silences events
  assign run = ctrl_q.en && tick && (perAct_q != '0);

  // next count and direction
  always_comb begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    zeroEvt = 1'b0;
    matchEvt = 1'b0;
    if (run) begin
      if (center) begin
        // up then down gives a period of twice the period value; edge modes take period plus one
        if (!dir_q) begin
          if (cnt_q >= perAct_q) begin
            dir_d = 1'b1;
            cnt_d = cnt_q - 1'b1;
            matchEvt = 1'b1;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end else begin
          if (cnt_q == '0) begin
            dir_d = 1'b0;
            cnt_d = cnt_q + 1'b1;
            zeroEvt = 1'b1;
          end else begin
            cnt_d = cnt_q - 1'b1;
          end
        end
      end else begin
        // free running and single shot count up only
        dir_d = 1'b0;
        if (cnt_q >= perAct_q) begin
          cnt_d = '0;
          matchEvt = 1'b1;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
    end
  end

  // counter and direction; a software write beats counting
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_q <= CNT_RST;
      dir_q <= 1'b0;
    end else if (clkEn) begin
      if (wrCnt) begin
        cnt_q <= pwdata[14:0];
      end else begin
        cnt_q <= cnt_d;
        dir_q <= dir_d;
      end
    end
  end

  // ---------------- events ----------------
  // event source per mode
  always_comb begin
    case (ctrl_q.mode)
      MPT_FREE: rawEvt = matchEvt;
      MPT_SINGLE: rawEvt = matchEvt;
      MPT_UPDN: rawEvt = zeroEvt;
      MPT_DUAL: rawEvt = zeroEvt || matchEvt;
      default: rawEvt = 1'b0;
    endcase
  end

  // single shot and double update ignore the postscaler
  assign usesPost = (ctrl_q.mode == MPT_FREE) || (ctrl_q.mode == MPT_UPDN);
  assign fire = rawEvt && (!usesPost || (post_q == ctrl_q.ops));

  // postscaler count
  always_ff @(posedge core_clk) begin
    if (reset) begin
      post_q <= '0;
    end else if (clkEn) begin
      if (wrCtrl || wrCnt) begin
        post_q <= '0;
      end else if (rawEvt && usesPost) begin
        post_q <= (post_q == ctrl_q.ops) ? 4'h0 : post_q + 1'b1;
      end
    end
  end

  // event pulse out, one cycle per postscaled event
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tbEvent_q <= 1'b0;
    end else if (clkEn) begin
      tbEvent_q <= fire;
    end
  end
  assign tbEvent = tbEvent_q;

  // sticky flag: a new event wins over a same-cycle clear
  always_ff @(posedge core_clk) begin
    if (reset) begin
      flag_q <= 1'b0;
    end else if (clkEn) begin
      if (fire) begin
        flag_q <= 1'b1;
      end else if (wrStat && pwdata[STAT_FLAG_BIT]) begin
        flag_q <= 1'b0;
      end
    end
  end

  // ---------------- control ----------------
  // single shot clears enable after its match unless software writes
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_q <= mpt_ctrl_s'(CTRL_RST);
      update_inhibit_bit_q <= 1'b0;
    end else if (clkEn) begin
      if (wrCtrl) begin
        ctrl_q.en <= pwdata[CTL_EN_BIT];
        ctrl_q.ops <= pwdata[CTL_OPS_LSB +: 4];
        ctrl_q.ckps <= pwdata[CTL_CKPS_LSB +: 2];
        ctrl_q.mode <= mpt_mode_e'(pwdata[CTL_MODE_LSB +: 2]);
      end else if (ctrl_q.mode == MPT_SINGLE && matchEvt) begin
        ctrl_q.en <= 1'b0;
      end
      if (wrOctl2) begin
        update_inhibit_bit_q <= pwdata[OCTL2_UPDATE_INHIBIT_BIT_BIT];
      end
    end
  end

  // ---------------- period double buffer ----------------
  // load at reset-after-match, at zero in up/down, always when disabled
  assign perLoad = !ctrl_q.en || (center ? zeroEvt : matchEvt);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      perBuf_q <= PER_RST;
      perAct_q <= PER_RST;
    end else if (clkEn) begin
      if (wrPer) begin
        perBuf_q <= pwdata[14:0];
      end
      if (perLoad) begin
        perAct_q <= perBuf_q;
      end
    end
  end

  // ---------------- duty buffers ----------------
  // update instants per mode; inhibit only holds edge-mode copies
  always_comb begin
    case (ctrl_q.mode)
      MPT_FREE: dutyLoad = matchEvt || (!ctrl_q.en && !update_inhibit_bit_q);
      MPT_SINGLE: dutyLoad = matchEvt || (!ctrl_q.en && !update_inhibit_bit_q);
      MPT_UPDN: dutyLoad = zeroEvt || !ctrl_q.en;
      MPT_DUAL: dutyLoad = zeroEvt || matchEvt || !ctrl_q.en;
      default: dutyLoad = 1'b0;
    endcase
  end

  // software side of each duty register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_CH; i++) begin
        dutyBuf_q[i] <= DUTY_RST;
      end
    end else if (clkEn && apbWr && dutyHit) begin
      dutyBuf_q[dutyIdx] <= pwdata[15:0];
    end
  end

  // ---------------- compare channels ----------------
  mpt_view_s view; // shared time base view
  assign view = '{cnt: cnt_q, half: half, per: perAct_q, center: center};

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    mpt_compare u_cmp (
      .core_clk(core_clk),
      .reset(reset),
      .clkEn(clkEn),
      .view(view),
      .load(dutyLoad),
      .dutyBuf(dutyBuf_q[g]),
      .dutyAct_q(),
      .out_q(compareOut[g])
    );
  end

  // ---------------- assertions ----------------
  updn_turn_a: assert property (@(posedge core_clk) disable iff (reset)
    run && center && !dir_q && cnt_q == perAct_q && !wrCnt
    |=> dir_q && cnt_q == $past(perAct_q) - 15'h0001) else $error("no turn at period match");

  dir_read_a: assert property (@(posedge core_clk) disable iff (reset)
    apbSetup && !pwrite && paddr == OFS_CNT ##1 psel && penable
    |-> prdata[CNT_DIR_BIT] == $past(dir_q)) else $error("direction flag misread");

  updn_evt_a: assert property (@(posedge core_clk) disable iff (reset)
    run && ctrl_q.mode == MPT_UPDN && dir_q && cnt_q == '0 |-> rawEvt) else $error("zero event missed");

  dual_evt_a: assert property (@(posedge core_clk) disable iff (reset)
    ctrl_q.mode == MPT_DUAL && (zeroEvt || matchEvt) |-> fire ##1 tbEvent) else $error("double update event lost");

  pre_clear_a: assert property (@(posedge core_clk) disable iff (reset)
    wrCtrl || wrCnt |=> preCnt == '0) else $error("prescaler not cleared");

  post_clear_a: assert property (@(posedge core_clk) disable iff (reset)
    wrCtrl || wrCnt |=> post_q == 4'h0) else $error("postscaler not cleared");

  per_copy_a: assert property (@(posedge core_clk) disable iff (reset)
    clkEn && !ctrl_q.en |=> perAct_q == $past(perBuf_q)) else $error("period not copied while disabled");

  per_zero_a: assert property (@(posedge core_clk) disable iff (reset)
    perAct_q == '0 && !wrCnt |=> $stable(cnt_q) && !tbEvent) else $error("zero period not stopped");

  cnt_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    !run && !wrCnt |=> $stable(cnt_q)) else $error("counter moved without a tick");

  single_stop_a: assert property (@(posedge core_clk) disable iff (reset)
    ctrl_q.mode == MPT_SINGLE && matchEvt && !wrCtrl |=> !ctrl_q.en ##1 !ctrl_q.en) else $error("single shot kept running");

  flag_set_a: assert property (@(posedge core_clk) disable iff (reset)
    fire |=> flag_q) else $error("event flag not set");

  // main scenarios
  updn_turn_c: cover property (@(posedge core_clk) disable iff (reset) zeroEvt ##[1:1000] matchEvt);
  single_c: cover property (@(posedge core_clk) disable iff (reset) ctrl_q.mode == MPT_SINGLE && matchEvt);
  flag_race_c: cover property (@(posedge core_clk) disable iff (reset) fire && wrStat);
  post_c: cover property (@(posedge core_clk) disable iff (reset) usesPost && rawEvt && ctrl_q.ops != 4'h0);

endmodule // mpt_timebase_duty

// [verif/mpt_gate_model.sv]
// mpt_gate_model: stand-in for the gate drivers fed by the compare outputs
// assumes active-high gate inputs and tbEvent marking one pwm window
module mpt_gate_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // pins from the block
  input wire logic [3:0] gateIn,
  input wire logic periodMark,
  // on-time of each gate over the last window, in core cycles
  output logic [3:0][15:0] onTime
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0][15:0] run; // running on-time since the last mark
  // a driver only sees levels, so on-time per window is what a load feels
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (reset) begin
        run[i] <= '0;
        onTime[i] <= '0;
      end else if (periodMark) begin
        onTime[i] <= run[i];
        run[i] <= 16'(gateIn[i]);
      end else begin
        run[i] <= run[i] + 16'(gateIn[i]);
      end
    end
  end
endmodule // mpt_gate_model

// [verif/tb_mpt_timebase_duty.sv]
// tb_mpt_timebase_duty: apb-driven tests of time base and duty channels
// assumes pready follows clkEn and the gate model watches the outputs
module tb_mpt_timebase_duty import mpt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, reset, clkEn, psel, penable, pwrite, pready, pslverr, tbEvent, rdErr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, keep;
  logic [3:0] compareOut;
  logic [3:0][15:0] onTime;
  int n_mismatch = 0;
  int checked = 0;
  int gap, nEv;
  // {ops, ckps, mode} per case and the expected event spacing at period 5
  logic [7:0] evCtl [8] = '{8'h00, 8'h20, 8'h04, 8'h08, 8'h0c, 8'h02, 8'h12, 8'h33};
  int evGap [8] = '{24, 72, 96, 384, 1536, 40, 80, 20};
  logic [15:0] dEdge [4] = '{16'h0, 16'h3, 16'hffff, 16'hb};
  logic [15:0] dCtr [4] = '{16'h0, 16'h4, 16'ha, 16'h6};
  int oEdge [4] = '{0, 6, 24, 22};
  int oCtr [4] = '{0, 12, 40, 20};

  mpt_timebase_duty #(.NUM_CH(4)) mpt_timebase_duty_inst (.core_clk(core_clk), .reset(reset),
    .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compareOut(compareOut), .tbEvent(tbEvent));
  mpt_gate_model mpt_gate_model_inst (.core_clk(core_clk), .reset(reset), .gateIn(compareOut),
    .periodMark(tbEvent), .onTime(onTime));

  // free-running 125 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // a hang counts as a mismatch and closes the run
  task automatic hang();
    n_mismatch++;
    $display("[ERR] %0t wait ran out", $time);
    end_sim();
  endtask
  // one apb transfer; starts on a fresh edge so strobes never change twice in a step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) hang();
    rd = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // cycles up to the next event pulse
  task automatic waitEv(output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (tbEvent !== 1'b1 && n < 3000);
    if (tbEvent !== 1'b1) hang();
  endtask
  // halt, load period and counter, then start; period 1 is never used, it floods events
  task automatic cfg(input logic [15:0] ctl, input logic [14:0] per);
    xfer(1'b1, OFS_CTRL, {16'h0, ctl});
    xfer(1'b1, OFS_PER, {17'h0, per});
    xfer(1'b1, OFS_CNT, 32'h0);
    xfer(1'b1, OFS_CTRL, {16'h0, ctl | 16'h8000});
  endtask

  initial begin
    reset = 1'b1;
    clkEn = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    // every register clears on reset
    for (int a = 0; a <= 32; a += 4) begin
      xfer(1'b0, 8'(a), 32'h0);
      chk(rd, 32'h0);
    end
    $display("reset values done");
    // free-running, up/down and double-update cases over all four prescales and postscales 1 to 3, measured on the event spacing
    for (int i = 0; i < 8; i++) begin
      cfg({8'h0, evCtl[i]}, 15'd5);
      waitEv(gap);
      waitEv(gap);
      chk(gap, evGap[i]);
    end
    $display("event timing done");
    // edge-aligned on-times, including zero and beyond the period
    for (int i = 0; i < 4; i++) xfer(1'b1, OFS_DUTY0 + 8'(4 * i), {16'h0, dEdge[i]});
    cfg(16'h0000, 15'd5);
    waitEv(gap);
    waitEv(gap);
    @(negedge core_clk);
    for (int i = 0; i < 4; i++) chk(onTime[i], oEdge[i]);
    $display("edge duty done");
    // center-aligned on-times
    for (int i = 0; i < 4; i++) xfer(1'b1, OFS_DUTY0 + 8'(4 * i), {16'h0, dCtr[i]});
    cfg(16'h0002, 15'd5);
    waitEv(gap);
    waitEv(gap);
    @(negedge core_clk);
    for (int i = 0; i < 4; i++) chk(onTime[i], oCtr[i]);
    $display("center duty done");
    // while counting down the flag is set and the count sits below the period
    // the first read is unconditional: rd still holds the last control word here
    xfer(1'b0, OFS_CNT, 32'h0);
    for (int i = 0; i < 40 && rd[15] !== 1'b1; i++) xfer(1'b0, OFS_CNT, 32'h0);
    chk(rd[15], 1'b1);
    chk(rd[14:0] < 15'd5, 1'b1);
    $display("direction done");
    // halting and rewriting control keep the count
    xfer(1'b1, OFS_CTRL, 32'h0002);
    xfer(1'b0, OFS_CNT, 32'h0);
    keep = rd;
    xfer(1'b1, OFS_CTRL, 32'h000e);
    xfer(1'b0, OFS_CNT, 32'h0);
    chk(rd, keep);
    $display("hold done");
    // sticky flag stays until written with one
    xfer(1'b0, OFS_STAT, 32'h0);
    chk(rd[0], 1'b1);
    xfer(1'b1, OFS_STAT, 32'h1);
    xfer(1'b0, OFS_STAT, 32'h0);
    chk(rd[0], 1'b0);
    $display("flag done");
    // single shot clears enable after its match
    cfg(16'h0001, 15'd5);
    waitEv(gap);
    xfer(1'b0, OFS_CTRL, 32'h0);
    chk(rd[15], 1'b0);
    $display("single shot done");
    // period zero: no counting, no events
    cfg(16'h0000, 15'd0);
    nEv = 0;
    repeat (300) begin
      @(posedge core_clk);
      if (tbEvent === 1'b1) nEv++;
    end
    chk(nEv, 0);
    xfer(1'b0, OFS_CNT, 32'h0);
    chk(rd, 32'h0);
    $display("period zero done");
    // unmapped place answers with an error and reads zero
    xfer(1'b0, 8'h40, 32'h0);
    chk(rdErr, 1'b1);
    chk(rd, 32'h0);
    $display("unmapped done");
    end_sim();
  end
endmodule // tb_mpt_timebase_duty
